/* File: hw/blank_toggle_gen.sv */
// Horizontal blank level generator driven by six toggle positions
`timescale 1ns/1ns
`default_nettype none
module blank_toggle_gen
  import hblank_cfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic line_start_in,
  input wire logic [POS_W-1:0] count_in,
  input wire logic [POS_W-1:0] pos_in [0:NUM_POS-1],
  input wire logic [NUM_POS-1:0] en_in,
  // Blank level
  output logic blank_out
);
  logic blank_r;
  logic blank_nxt;
  logic [NUM_POS-1:0] hit;

  always_comb
  begin
    for (int k = 0; k < NUM_POS; k++)
    begin
      hit[k] = en_in[k] && (count_in == pos_in[k]);
    end
    blank_nxt = blank_r;
    // Every line starts unblanked so a lost toggle cannot carry over
    if (line_start_in || !run_in)
    begin
      blank_nxt = 1'b0;
    end
    else if (|hit)
    begin
      blank_nxt = ~blank_r; // R11
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      blank_r <= 1'b0;
    end
    else
    begin
      blank_r <= blank_nxt;
    end
  end

  assign blank_out = blank_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  blank_toggle_a: assert property (run_in && !line_start_in && (|hit) |=> blank_r != $past(blank_r)) // R11
    else $error("blank level did not toggle on a matching position");
  blank_hold_a: assert property (run_in && !line_start_in && !(|hit) |=> $stable(blank_r)) // R11
    else $error("blank level changed without a matching position");
  blank_toggle_c: cover property (run_in && (|hit) ##1 blank_r);
endmodule
`default_nettype wire

/* File: hw/hblank_cfg_pkg.sv */
// Constants shared by the blanking configuration bank and its blank generator
package hblank_cfg_pkg;
  // ****************************************
  // Field geometry
  // ****************************************
  localparam int POS_W = 13;
  localparam int NUM_POS = 6;
  localparam int NUM_REGS = 9;
  localparam logic [12:0] POS_MAX = 13'h1fff;
  localparam int FIELD_LO_LSB = 0;
  localparam int FIELD_HI_LSB = 13;
  localparam int EVEN_MASK_LSB = 13;
  localparam int ODD_MASK_LSB = 17;
  localparam int MASK_W = 4;
  localparam int PAT_W = 3;
  localparam int PAT_STRIDE = 4;
  localparam logic [2:0] AREA_LAST = 3'h5;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_BASE = 6'h19;
  localparam logic [5:0] IDX_ODD_1_2 = 6'h19;
  localparam logic [5:0] IDX_ODD_3_4 = 6'h1a;
  localparam logic [5:0] IDX_ODD_5_6 = 6'h1b;
  localparam logic [5:0] IDX_EVEN_1_2 = 6'h1c;
  localparam logic [5:0] IDX_EVEN_3_4 = 6'h1d;
  localparam logic [5:0] IDX_EVEN_5_6 = 6'h1e;
  localparam logic [5:0] IDX_START_A_B = 6'h1f;
  localparam logic [5:0] IDX_START_C_MASK = 6'h20;
  localparam logic [5:0] IDX_PATTERN_ODD = 6'h21;
  localparam logic [5:0] IDX_CTRL = 6'h30;
  localparam logic [5:0] IDX_STATUS = 6'h31;

  // Positions inside the register array
  localparam int I_ODD = 0;
  localparam int I_EVEN = 3;
  localparam int I_START_A_B = 6;
  localparam int I_START_C_MASK = 7;
  localparam int I_PATTERN = 8;

  // ****************************************
  // Implemented bits and reset values
  // ****************************************
  localparam logic [31:0] MASK_26 = 32'h03ff_ffff;
  localparam logic [31:0] MASK_21 = 32'h001f_ffff;
  localparam logic [31:0] MASK_PAT = 32'h0077_7777;
  localparam logic [31:0] MASK_CTRL = 32'h0000_007f;
  localparam logic [31:0] RST_TOGGLE = 32'h0000_0000;
  localparam logic [31:0] RST_START_A_B = 32'h03ff_ffff;
  localparam logic [31:0] RST_START_C_MASK = 32'h0000_1fff;
  localparam logic [31:0] RST_PATTERN = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;

  // Control and status bit positions
  localparam int CTRL_ALT_BIT = 0;
  localparam int CTRL_EN_LSB = 1;
  localparam int STAT_BLANK_BIT = 0;
  localparam int STAT_REGION_LSB = 1;
  localparam int STAT_ALT_BIT = 3;

  // Repeat region codes
  typedef enum logic [1:0] {REGION_NONE, REGION_A, REGION_B, REGION_C} region_t;
endpackage

/* File: hw/hblank_toggle_repeat_cfg.sv */
// Blanking toggle and repeat-area configuration bank with Wishbone slave
// How it works
// R1 - The third to sixth odd-line toggle positions sit as two 13-bit fields per register, lower one in the low bits.
// R2 - Six further 13-bit toggle positions for even lines sit two per register in three consecutive registers.
// R3 - In alternate mode each odd-line field is the first clock group's repeat setting for repeat areas 0 to 5.
// R4 - In alternate mode each even-line field is the second clock group's repeat setting for the same area.
// R5 - Three 13-bit start positions A, B and C place the repeat areas along the line in alternate mode.
// R6 - Software sets an unused start position to 8191 so that its area is never entered.
// R7 - A 4-bit even-line mask enables freeze and resume for vertical groups A to D on even lines.
// R8 - A 4-bit odd-line mask enables freeze and resume for vertical groups A to D on odd lines.
// R9 - Six 3-bit odd-line pattern selectors for areas 0 to 5 sit one per nibble, top nibble bit unused.
// R10 - The first and second odd-line toggle positions sit in the register just before this set.
// R11 - Outside alternate mode the blank output toggles whenever the pixel count hits an enabled position, except in a line-start cycle, which clears it.
`timescale 1ns/1ns
`default_nettype none
module hblank_toggle_repeat_cfg
  import hblank_cfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [7:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic [31:0] dat_out,
  output logic ack_out,
  // Line timing
  input wire logic line_start_in,
  input wire logic line_odd_in,
  input wire logic [POS_W-1:0] count_in,
  input wire logic [2:0] repeat_area_in,
  // Blanking and repeat outputs
  output logic horizontal_blank_out,
  output logic alternate_blank_mode_out,
  output logic [1:0] repeat_region_out,
  output logic [POS_W-1:0] area_first_group_repeat_out,
  output logic [POS_W-1:0] area_second_group_repeat_out,
  output logic [PAT_W-1:0] repeat_area_pattern_sel_out,
  // Freeze enables per vertical group
  output logic [MASK_W-1:0] even_line_freeze_enable_out,
  output logic [MASK_W-1:0] odd_line_freeze_enable_out
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [POS_W-1:0] field13(input logic [31:0] w, input logic hi);
    field13 = hi ? w[FIELD_HI_LSB +: POS_W] : w[FIELD_LO_LSB +: POS_W];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic [31:0] reg_mask(input int i);
    if (i == I_START_C_MASK)
    begin
      reg_mask = MASK_21;
    end
    else if (i == I_PATTERN)
    begin
      reg_mask = MASK_PAT;
    end
    else
    begin
      reg_mask = MASK_26;
    end
  endfunction

  function automatic logic [31:0] reg_reset(input int i);
    if (i == I_START_A_B)
    begin
      reg_reset = RST_START_A_B;
    end
    else if (i == I_START_C_MASK)
    begin
      reg_reset = RST_START_C_MASK;
    end
    else if (i == I_PATTERN)
    begin
      reg_reset = RST_PATTERN;
    end
    else
    begin
      reg_reset = RST_TOGGLE;
    end
  endfunction

  // An unused start left at the maximum can never be reached
  function automatic logic passed(input logic [POS_W-1:0] start, input logic [POS_W-1:0] cnt);
    passed = (start != POS_MAX) && (cnt >= start); // R6
  endfunction

  // ****************************************
  // Register bank and bus slave
  // ****************************************
  logic [31:0] regs_r [0:NUM_REGS-1];
  logic [31:0] regs_nxt [0:NUM_REGS-1];
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [5:0] idx;
  logic req;
  logic blank_w;
  logic alt;
  region_t region_r;
  region_t region_nxt;

  assign idx = adr_in[7:2];
  assign req = cyc_in && stb_in && !ack_r;
  assign alt = ctrl_r[CTRL_ALT_BIT];

  // Writes land on the edge that raises ack; unmapped words read zero and drop writes
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      regs_nxt[i] = regs_r[i];
    end
    ctrl_nxt = ctrl_r;
    dat_nxt = dat_r;
    ack_nxt = req;
    if (req && we_in)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (idx == IDX_BASE + 6'(i))
        begin
          regs_nxt[i] = merge(regs_r[i], dat_in, sel_in) & reg_mask(i); // R1 R2 R5 R7 R8 R9 R10
        end
      end
      if (idx == IDX_CTRL)
      begin
        ctrl_nxt = merge(ctrl_r, dat_in, sel_in) & MASK_CTRL;
      end
    end
    else if (req)
    begin
      dat_nxt = 32'h0000_0000;
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (idx == IDX_BASE + 6'(i))
        begin
          dat_nxt = regs_r[i];
        end
      end
      if (idx == IDX_CTRL)
      begin
        dat_nxt = ctrl_r;
      end
      if (idx == IDX_STATUS)
      begin
        dat_nxt[STAT_BLANK_BIT] = blank_w;
        dat_nxt[STAT_REGION_LSB +: 2] = region_r;
        dat_nxt[STAT_ALT_BIT] = alt;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= reg_reset(i);
      end
      ctrl_r <= RST_CTRL;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= regs_nxt[i];
      end
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ack_out = ack_r;
  assign dat_out = dat_r;

  // ****************************************
  // Blank generator
  // ****************************************
  logic [POS_W-1:0] pos [0:NUM_POS-1];

  always_comb
  begin
    for (int k = 0; k < NUM_POS; k++)
    begin
      pos[k] = field13(regs_r[(line_odd_in ? I_ODD : I_EVEN) + k / 2], k[0]); // R1 R2 R10
    end
  end

  blank_toggle_gen u_blank
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(!alt),
    .line_start_in(line_start_in),
    .count_in(count_in),
    .pos_in(pos),
    .en_in(ctrl_r[CTRL_EN_LSB +: NUM_POS]),
    .blank_out(blank_w)
  );

  assign horizontal_blank_out = blank_w;

  // ****************************************
  // Repeat areas and freeze enables
  // ****************************************
  logic [POS_W-1:0] first_r;
  logic [POS_W-1:0] first_nxt;
  logic [POS_W-1:0] second_r;
  logic [POS_W-1:0] second_nxt;
  logic [PAT_W-1:0] pat_r;
  logic [PAT_W-1:0] pat_nxt;
  logic [MASK_W-1:0] even_en_r;
  logic [MASK_W-1:0] odd_en_r;
  logic alt_r;
  logic area_ok;
  int sel_i;

  always_comb
  begin
    area_ok = alt && (repeat_area_in <= AREA_LAST);
    sel_i = int'(repeat_area_in[2:1]);
    first_nxt = '0;
    second_nxt = '0;
    pat_nxt = '0;
    if (area_ok)
    begin
      first_nxt = field13(regs_r[I_ODD + sel_i], repeat_area_in[0]); // R3
      second_nxt = field13(regs_r[I_EVEN + sel_i], repeat_area_in[0]); // R4
      pat_nxt = regs_r[I_PATTERN][{repeat_area_in, 2'b00} +: PAT_W]; // R9
    end
    region_nxt = REGION_NONE;
    if (alt)
    begin
      if (passed(regs_r[I_START_A_B][FIELD_LO_LSB +: POS_W], count_in))
      begin
        region_nxt = REGION_A; // R5
      end
      if (passed(regs_r[I_START_A_B][FIELD_HI_LSB +: POS_W], count_in))
      begin
        region_nxt = REGION_B; // R5
      end
      if (passed(regs_r[I_START_C_MASK][FIELD_LO_LSB +: POS_W], count_in))
      begin
        region_nxt = REGION_C; // R5
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      first_r <= '0;
      second_r <= '0;
      pat_r <= '0;
      region_r <= REGION_NONE;
      even_en_r <= '0;
      odd_en_r <= '0;
      alt_r <= 1'b0;
    end
    else
    begin
      first_r <= first_nxt;
      second_r <= second_nxt;
      pat_r <= pat_nxt;
      region_r <= region_nxt;
      even_en_r <= regs_r[I_START_C_MASK][EVEN_MASK_LSB +: MASK_W]; // R7
      odd_en_r <= regs_r[I_START_C_MASK][ODD_MASK_LSB +: MASK_W]; // R8
      alt_r <= alt;
    end
  end

  assign area_first_group_repeat_out = first_r;
  assign area_second_group_repeat_out = second_r;
  assign repeat_area_pattern_sel_out = pat_r;
  assign repeat_region_out = region_r;
  assign even_line_freeze_enable_out = even_en_r;
  assign odd_line_freeze_enable_out = odd_en_r;
  assign alternate_blank_mode_out = alt_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  ack_answer_a: assert property (cyc_in && stb_in && !ack_r |=> ack_r ##1 !ack_r)
    else $error("ack did not follow the request as one pulse");
  odd_store_a: assert property (req && we_in && idx == IDX_ODD_3_4 && sel_in == 4'hf ##1 ack_r
      |-> regs_r[I_ODD + 1] == ($past(dat_in, 1) & MASK_26)) // R1
    else $error("odd toggle word not stored");
  even_store_a: assert property (req && we_in && idx == IDX_EVEN_5_6 && sel_in == 4'hf
      |=> regs_r[I_EVEN + 2][25:13] == $past(dat_in[25:13])) // R2
    else $error("even toggle word not stored");
  first_repeat_a: assert property (alt && repeat_area_in == 3'h3 |=> first_r == $past(regs_r[I_ODD + 1][25:13])) // R3
    else $error("first group repeat wrong for area 3");
  second_repeat_a: assert property (alt && repeat_area_in == 3'h4 |=> second_r == $past(regs_r[I_EVEN + 2][12:0])) // R4
    else $error("second group repeat wrong for area 4");
  region_off_a: assert property (!alt |=> region_r == REGION_NONE) // R5
    else $error("repeat region reported outside alternate mode");
  never_enter_a: assert property (regs_r[I_START_A_B] == MASK_26 && regs_r[I_START_C_MASK][12:0] == POS_MAX
      |=> region_r == REGION_NONE) // R6
    else $error("unused start position entered");
  even_mask_a: assert property (##1 even_en_r == $past(regs_r[I_START_C_MASK][16:13])) // R7
    else $error("even freeze enable mismatch");
  odd_mask_a: assert property (##1 odd_en_r == $past(regs_r[I_START_C_MASK][20:17])) // R8
    else $error("odd freeze enable mismatch");
  pattern_sel_a: assert property (alt && repeat_area_in == 3'h5 |=> pat_r == $past(regs_r[I_PATTERN][22:20])) // R9
    else $error("pattern selector wrong for area 5");
  first_pos_a: assert property (req && we_in && idx == IDX_ODD_1_2 && sel_in == 4'hf
      |=> regs_r[I_ODD][12:0] == $past(dat_in[12:0])) // R10
    else $error("first odd toggle position not stored");
  alt_blank_a: assert property (alt_r && alt |=> !horizontal_blank_out) // R11
    else $error("blank toggled in alternate mode");

  bus_write_c: cover property (req && we_in ##1 ack_r);
  region_c_c: cover property (region_r == REGION_C);
  pattern_c: cover property (alt && pat_r != '0);
endmodule
`default_nettype wire

/* File: sim/hblank_toggle_repeat_cfg_test.sv */
// Self-checking testbench for the blanking toggle and repeat-area configuration bank
`timescale 1ns/1ns
`default_nettype none
module hblank_toggle_repeat_cfg_test
  import hblank_cfg_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_out;
  logic ack_out;
  logic line_start_in = 1'b0;
  logic line_odd_in = 1'b0;
  logic [POS_W-1:0] count_in = 13'h0000;
  logic [2:0] repeat_area_in = 3'h7;
  logic horizontal_blank_out;
  logic alternate_blank_mode_out;
  logic [1:0] repeat_region_out;
  logic [POS_W-1:0] area_first_group_repeat_out;
  logic [POS_W-1:0] area_second_group_repeat_out;
  logic [PAT_W-1:0] repeat_area_pattern_sel_out;
  logic [MASK_W-1:0] even_line_freeze_enable_out;
  logic [MASK_W-1:0] odd_line_freeze_enable_out;
  logic [31:0] shadow [0:9];
  int n_mismatch = 0;
  int compares = 0;

  hblank_toggle_repeat_cfg dut_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .cyc_in(cyc), .stb_in(stb), .we_in(we), .adr_in(adr),
    .sel_in(sel), .dat_in(dat_w), .dat_out(dat_out), .ack_out(ack_out), .line_start_in(line_start_in),
    .line_odd_in(line_odd_in), .count_in(count_in), .repeat_area_in(repeat_area_in),
    .horizontal_blank_out(horizontal_blank_out), .alternate_blank_mode_out(alternate_blank_mode_out),
    .repeat_region_out(repeat_region_out), .area_first_group_repeat_out(area_first_group_repeat_out),
    .area_second_group_repeat_out(area_second_group_repeat_out),
    .repeat_area_pattern_sel_out(repeat_area_pattern_sel_out),
    .even_line_freeze_enable_out(even_line_freeze_enable_out),
    .odd_line_freeze_enable_out(odd_line_freeze_enable_out));

  always #50 mclk_in = ~mclk_in;

  // ****************************************
  // Expectation helpers
  // ****************************************
  // Shadow slots 0..8 follow the map from the first odd word on, slot 9 is control
  function automatic int sidx(input logic [5:0] i);
    if (i >= IDX_BASE && i <= IDX_PATTERN_ODD)
      return int'(i - IDX_BASE);
    if (i == IDX_CTRL)
      return 9;
    return -1;
  endfunction

  function automatic logic [31:0] fmask(input int s);
    if (s >= 0 && s <= 6)
      return MASK_26;
    if (s == 7)
      return MASK_21;
    if (s == 8)
      return MASK_PAT;
    return MASK_CTRL;
  endfunction

  function automatic logic [31:0] rst_val(input int s);
    if (s == 6)
      return RST_START_A_B;
    if (s == 7)
      return RST_START_C_MASK;
    if (s == 8)
      return RST_PATTERN;
    if (s == 9)
      return RST_CTRL;
    return RST_TOGGLE;
  endfunction

  function automatic logic [12:0] fld(input logic [31:0] w, input int hi);
    return (hi != 0) ? w[25:13] : w[12:0];
  endfunction

  function automatic logic [1:0] region(input logic [12:0] c);
    logic [1:0] r;
    r = 2'h0;
    if (shadow[6][12:0] != POS_MAX && c >= shadow[6][12:0])
      r = 2'h1;
    if (shadow[6][25:13] != POS_MAX && c >= shadow[6][25:13])
      r = 2'h2;
    if (shadow[7][12:0] != POS_MAX && c >= shadow[7][12:0])
      r = 2'h3;
    return r;
  endfunction

  // Equal positions count once, so the result is a single hit flag
  function automatic logic hit(input logic [12:0] c, input logic odd, input logic [5:0] en);
    logic h;
    h = 1'b0;
    for (int k = 0; k < NUM_POS; k++)
      if (en[k] && fld(shadow[(odd ? 0 : 3) + k / 2], k % 2) == c)
        h = 1'b1;
    return h;
  endfunction

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] i, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    int k;
    logic [31:0] lm;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= s;
    dat_w <= d;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (ack_out !== 1'b1 && n < 20);
    if (ack_out !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: ack seen %h expected %h", $time, ack_out, 1'b1);
    end
    q = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    k = sidx(i);
    if (w && k >= 0)
      shadow[k] = ((shadow[k] & ~lm) | (d & lm)) & fmask(k);
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, 4'hf, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] i);
    logic [31:0] q;
    bus(1'b0, i, 4'h0, 32'h0000_0000, q);
    check(q, (sidx(i) >= 0) ? shadow[sidx(i)] : 32'h0000_0000);
  endtask

  task automatic end_of_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles; this is a generous ceiling
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    logic [31:0] q;
    logic [12:0] cnts [0:7];
    logic [5:0] en;
    logic ex;
    void'($urandom(60976));
    for (int s = 0; s < 10; s++)
      shadow[s] = rst_val(s);
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 'h19; i <= 'h21; i++)
      rd_chk(6'(i));
    rd_chk(IDX_CTRL);
    rd_chk(IDX_STATUS);
    rd_chk(6'h3f);
    check(32'(even_line_freeze_enable_out), 32'h0);
    check(32'(odd_line_freeze_enable_out), 32'h0);
    $display("test reset_values done");

    // Second pass uses random byte lanes to catch lane mix-ups
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 'h19; i <= 'h21; i++)
        bus(1'b1, 6'(i), (p == 0) ? 4'hf : 4'($urandom), $urandom, q);
      bus(1'b1, 6'h3f, 4'hf, $urandom, q);
      for (int i = 'h19; i <= 'h21; i++)
        rd_chk(6'(i));
      rd_chk(6'h3f);
      @(negedge mclk_in);
      check(32'(even_line_freeze_enable_out), 32'(shadow[7][16:13]));
      check(32'(odd_line_freeze_enable_out), 32'(shadow[7][20:17]));
    end
    $display("test register_access done");

    cnts = '{13'd50, 13'd100, 13'd199, 13'd200, 13'd250, 13'd300, 13'h1fff, 13'd0};
    wr(IDX_START_A_B, {6'h00, 13'd200, 13'd100});
    wr(IDX_CTRL, 32'h0000_0001);
    for (int p = 0; p < 2; p++)
    begin
      // First pass leaves area C unused at the top value, second places it
      wr(IDX_START_C_MASK, {shadow[7][31:13], (p == 0) ? POS_MAX : 13'd300});
      for (int a = 0; a < 8; a++)
      begin
        @(posedge mclk_in);
        repeat_area_in <= 3'(a);
        count_in <= cnts[a];
        @(posedge mclk_in);
        @(negedge mclk_in);
        check(32'(area_first_group_repeat_out), (a < 6) ? 32'(fld(shadow[a / 2], a % 2)) : 32'h0);
        check(32'(area_second_group_repeat_out), (a < 6) ? 32'(fld(shadow[3 + a / 2], a % 2)) : 32'h0);
        check(32'(repeat_area_pattern_sel_out), (a < 6) ? 32'((shadow[8] >> (4 * a)) & 32'h7) : 32'h0);
        check(32'(repeat_region_out), 32'(region(cnts[a])));
        check(32'(alternate_blank_mode_out), 32'h1);
        check(32'(horizontal_blank_out), 32'h0);
      end
    end
    // Status shows the live region in alternate mode: count 250 lies past B but short of C
    @(posedge mclk_in);
    count_in <= 13'd250;
    bus(1'b0, IDX_STATUS, 4'h0, 32'h0000_0000, q);
    check(q, 32'({1'b1, region(13'd250), 1'b0}));
    $display("test alternate_mode done");

    wr(IDX_ODD_1_2, {6'h00, 13'd20, 13'd10});
    wr(IDX_ODD_3_4, {6'h00, 13'd40, 13'd30});
    wr(IDX_ODD_5_6, {6'h00, 13'd60, 13'd50});
    wr(IDX_EVEN_1_2, {6'h00, 13'd25, 13'd15});
    wr(IDX_EVEN_3_4, {6'h00, 13'd45, 13'd35});
    wr(IDX_EVEN_5_6, {6'h00, 13'd55, 13'd55});
    repeat_area_in <= 3'h7;
    for (int p = 0; p < 4; p++)
    begin
      en = (p > 1) ? 6'(6'h3f ^ (1 << ($urandom % 6))) : 6'h3f;
      wr(IDX_CTRL, {25'h0, en, 1'b0});
      line_odd_in <= p[0];
      ex = 1'b0;
      for (int c = 0; c <= 70; c++)
      begin
        @(posedge mclk_in);
        count_in <= 13'(c);
        line_start_in <= (c == 0);
        @(negedge mclk_in);
        if (c > 0)
          check(32'(horizontal_blank_out), 32'(ex));
        ex = (c == 0) ? 1'b0 : ex ^ hit(13'(c), p[0], en);
      end
    end
    $display("test blank_toggle done");
    end_of_test();
  end
endmodule
`default_nettype wire
